// >>> verilog/stm_top.v
`timescale 1ns/1ps
`include "stm_regs.vh"
module stm_top (
  input wire mclk,
  input wire rst,
  input wire [1:0] mode_pin,
  input wire addr_strobe_n,
  input wire [3:0] function_code_lines,
  input wire [`STM_AW-1:0] logical_address_lines,
  input wire mapped_strobe_in,
  input wire unit_op_done,
  input wire [`STM_AW-1:0] load_logical_base,
  input wire [`STM_AW-1:0] load_logical_mask,
  input wire [`STM_AW-1:0] load_physical_base,
  input wire [`STM_SW-1:0] load_space_number,
  input wire [`STM_SW-1:0] load_space_mask,
  input wire [1:0] load_index,
  input wire load_strobe,
  input wire [`STM_NDESC-1:0] write_protect,
  output reg mapped_strobe,
  output reg [`STM_AW-1:0] physical_addr_data_lines,
  output reg physical_addr_oe,
  output reg all_miss_out,
  output reg write_inhibit
);
  reg [1:0] mode_s1_q;
  reg [1:0] mode_q;
  reg mode_cap_q;
  reg mode_arm_q;
  reg late_q;
  reg as_s1_q;
  reg as_s2_q;
  reg min_s1_q;
  reg min_s2_q;
  reg [3:0] fc_s1_q;
  reg [3:0] fc_s2_q;
  reg [`STM_AW-1:0] la_s1_q;
  reg [`STM_AW-1:0] la_s2_q;
  reg [`STM_AW-1:0] lbase_q [0:`STM_NDESC-1];
  reg [`STM_AW-1:0] lmask_q [0:`STM_NDESC-1];
  reg [`STM_AW-1:0] pbase_q [0:`STM_NDESC-1];
  reg [`STM_SW-1:0] snum_q [0:`STM_NDESC-1];
  reg [`STM_SW-1:0] smask_q [0:`STM_NDESC-1];
  reg [`STM_NDESC-1:0] en_q;
  reg after_op_q;
  reg valid_q;
  reg rise_q;
  reg fall_q;
  reg [`STM_AW-1:0] paddr_q;
  reg wp_q;
  reg hit_q;
  wire [`STM_NDESC-1:0] hits;
  wire [`STM_AW-1:0] paddrs [0:`STM_NDESC-1];
  wire [`STM_SW-1:0] cyc_snum;
  reg any_hit;
  reg [`STM_AW-1:0] sel_paddr;
  reg sel_wp;
  reg strobe_d;
  integer i;
  genvar g;

  // Space number derived from function code; upper bits zero
  assign cyc_snum = {4'h0, fc_s2_q};

  generate
    for (g = 0; g < `STM_NDESC; g = g + 1)
    begin : gdesc
      stm_match u_match (
        .laddr(la_s2_q),
        .snum(cyc_snum),
        .lbase(lbase_q[g]),
        .lmask(lmask_q[g]),
        .pbase(pbase_q[g]),
        .dsnum(snum_q[g]),
        .smask(smask_q[g]),
        .enable(en_q[g]),
        .hit(hits[g]),
        .paddr(paddrs[g])
      );
    end
  endgenerate

  // Lowest-numbered matching descriptor wins
  always @*
  begin
    any_hit = 1'b0;
    sel_paddr = {`STM_AW{1'b0}};
    sel_wp = 1'b0;
    for (i = `STM_NDESC - 1; i >= 0; i = i - 1)
    begin
      if (hits[i])
      begin
        any_hit = 1'b1;
        sel_paddr = paddrs[i];
        sel_wp = write_protect[i];
      end
    end
  end

  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      mode_s1_q <= 2'h0;
      as_s1_q <= 1'b1;
      as_s2_q <= 1'b1;
      min_s1_q <= 1'b1;
      min_s2_q <= 1'b1;
      fc_s1_q <= 4'h0;
      fc_s2_q <= 4'h0;
      la_s1_q <= {`STM_AW{1'b0}};
      la_s2_q <= {`STM_AW{1'b0}};
    end
    else
    begin
      mode_s1_q <= mode_pin;
      as_s1_q <= addr_strobe_n;
      as_s2_q <= as_s1_q;
      min_s1_q <= mapped_strobe_in;
      min_s2_q <= min_s1_q;
      fc_s1_q <= function_code_lines;
      fc_s2_q <= fc_s1_q;
      la_s1_q <= logical_address_lines;
      la_s2_q <= la_s1_q;
    end
  end

  // Strap captured once, after it has passed its one flop mode_s1_q
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      mode_q <= `STM_MODE_ASYNC;
      mode_cap_q <= 1'b0;
      mode_arm_q <= 1'b0;
    end
    else
    begin
      mode_arm_q <= 1'b1;
      if (mode_arm_q && !mode_cap_q)
      begin
        mode_q <= mode_s1_q;
        mode_cap_q <= 1'b1;
      end
    end
  end

  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      for (i = 0; i < `STM_NDESC; i = i + 1)
      begin
        lbase_q[i] <= `STM_D0_LBASE;
        lmask_q[i] <= `STM_D0_LMASK;
        pbase_q[i] <= `STM_D0_PBASE;
        snum_q[i] <= `STM_D0_SNUM;
        smask_q[i] <= `STM_D0_SMASK;
      end
      en_q <= {{(`STM_NDESC-1){1'b0}}, 1'b1};
    end
    else if (load_strobe)
    begin
      lbase_q[load_index] <= load_logical_base;
      lmask_q[load_index] <= load_logical_mask;
      pbase_q[load_index] <= load_physical_base;
      snum_q[load_index] <= load_space_number;
      smask_q[load_index] <= load_space_mask;
      en_q[load_index] <= 1'b1;
    end
  end

  // True while a translated address is on the bus in an open cycle
  function addr_live;
    input oe;
    input v;
    input as_n;
    begin
      addr_live = oe && v && !as_n;
    end
  endfunction

  // Set by a unit operation, held until a strobe has been given
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
      after_op_q <= 1'b0;
    else if (unit_op_done)
      after_op_q <= 1'b1;
    else if (mapped_strobe)
      after_op_q <= 1'b0;
  end

  // Translation pipeline; address presented at least one cycle before strobe
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      valid_q <= 1'b0;
      hit_q <= 1'b0;
      paddr_q <= {`STM_AW{1'b0}};
      wp_q <= 1'b0;
    end
    else
    begin
      valid_q <= !as_s2_q && min_s2_q && any_hit;
      hit_q <= any_hit;
      paddr_q <= sel_paddr;
      wp_q <= sel_wp;
    end
  end

  // Registered outputs toward the physical bus
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      all_miss_out <= 1'b0;
      physical_addr_data_lines <= {`STM_AW{1'b0}};
      physical_addr_oe <= 1'b0;
      write_inhibit <= 1'b0;
    end
    else
    begin
      // Unmasked low lines carry the logical address but still pass this flop
      physical_addr_data_lines <= valid_q ? paddr_q : {`STM_AW{1'b0}};
      physical_addr_oe <= valid_q;
      write_inhibit <= valid_q && wp_q;
      all_miss_out <= !as_s2_q && (!min_s2_q || !any_hit);
    end
  end

  // Rising-edge stage and its later copy for the after-op case
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      rise_q <= 1'b0;
      late_q <= 1'b0;
    end
    else
    begin
      rise_q <= addr_live(physical_addr_oe, valid_q, as_s2_q);
      late_q <= rise_q;
    end
  end

  // Falling-edge stage watches the driven address
  always @(negedge mclk or posedge rst)
  begin
    if (rst)
      fall_q <= 1'b0;
    else
      fall_q <= addr_live(physical_addr_oe, valid_q, as_s2_q);
  end

  // Every mode waits one stage longer after a unit operation
  always @*
  begin
    case (mode_q)
      `STM_MODE_ASYNC:
        // Immediate unless a unit operation preceded
        strobe_d = after_op_q ? rise_q && fall_q : physical_addr_oe && valid_q;
      `STM_MODE_RISE:
        strobe_d = after_op_q ? late_q : rise_q;
      `STM_MODE_FALL:
        strobe_d = after_op_q ? rise_q && fall_q : fall_q;
      default:
        strobe_d = 1'b0;
    endcase
  end

  // Output flop; gated so strobe never stands without address
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
      mapped_strobe <= 1'b0;
    else
      mapped_strobe <= strobe_d && valid_q && hit_q;
  end
endmodule

// >>> verilog/stm_regs.vh
`ifndef STM_REGS_VH
`define STM_REGS_VH
`define STM_NDESC 4
`define STM_AW 16
`define STM_SW 8
`define STM_MODE_ASYNC 2'h0
`define STM_MODE_RISE 2'h1
`define STM_MODE_FALL 2'h2
`define STM_D0_LBASE 16'h0000
`define STM_D0_LMASK 16'h0000
`define STM_D0_PBASE 16'h0000
`define STM_D0_SNUM 8'h00
`define STM_D0_SMASK 8'hff
`endif

// >>> verilog/stm_match.v
`timescale 1ns/1ps
`include "stm_regs.vh"
module stm_match (
  input wire [`STM_AW-1:0] laddr,
  input wire [`STM_SW-1:0] snum,
  input wire [`STM_AW-1:0] lbase,
  input wire [`STM_AW-1:0] lmask,
  input wire [`STM_AW-1:0] pbase,
  input wire [`STM_SW-1:0] dsnum,
  input wire [`STM_SW-1:0] smask,
  input wire enable,
  output wire hit,
  output wire [`STM_AW-1:0] paddr
);
  // Masked-out bits are free: segment covers every substitution
  assign hit = enable &&
    (((laddr ^ lbase) & lmask) == {`STM_AW{1'b0}}) &&
    (((snum ^ dsnum) & smask) == {`STM_SW{1'b0}});
  assign paddr = (laddr & ~lmask) | (pbase & lmask);
endmodule

// >>> bench/stm_top_monitor.sv
`timescale 1ns/1ps
`include "stm_regs.vh"
module stm_top_monitor (
  input wire mclk,
  input wire rst,
  input wire addr_strobe_n,
  input wire mapped_strobe_in,
  input wire mapped_strobe,
  input wire [`STM_AW-1:0] physical_addr_data_lines,
  input wire physical_addr_oe,
  input wire all_miss_out
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  property p_strb;
    mapped_strobe |-> physical_addr_oe;
  endproperty
  a_strb: assert property (p_strb) else $error("strobe without address");
  property p_miss;
    all_miss_out |-> !mapped_strobe && !physical_addr_oe;
  endproperty
  a_miss: assert property (p_miss) else $error("strobe on miss");
  property p_supp;
    !mapped_strobe_in [*6] |-> !physical_addr_oe;
  endproperty
  a_supp: assert property (p_supp) else $error("drove when suppressed");
  property p_smiss;
    (!addr_strobe_n && !mapped_strobe_in) [*7] |-> all_miss_out;
  endproperty
  a_smiss: assert property (p_smiss) else $error("no miss report");
  property p_idle;
    addr_strobe_n [*6] |-> !physical_addr_oe && !all_miss_out;
  endproperty
  a_idle: assert property (p_idle) else $error("output without cycle");
  property p_first;
    $rose(physical_addr_oe) |-> !mapped_strobe;
  endproperty
  a_first: assert property (p_first) else $error("strobe too early");
  property p_bound;
    $rose(physical_addr_oe) ##1 physical_addr_oe [*4] |-> mapped_strobe;
  endproperty
  a_bound: assert property (p_bound) else $error("strobe too late");
  property p_stab;
    physical_addr_oe && $past(physical_addr_oe)
      |-> $stable(physical_addr_data_lines);
  endproperty
  a_stab: assert property (p_stab) else $error("address moved");
  cover property ($rose(mapped_strobe));
  cover property (all_miss_out && !mapped_strobe_in);
  cover property (all_miss_out && mapped_strobe_in);
endmodule
bind stm_top stm_top_monitor stm_top_monitor_inst (.mclk, .rst,
  .addr_strobe_n, .mapped_strobe_in, .mapped_strobe,
  .physical_addr_data_lines, .physical_addr_oe, .all_miss_out);

// >>> bench/stm_cpu.sv
`timescale 1ns/1ps
module stm_cpu (
  output reg as_n,
  output reg [3:0] fc,
  output reg [15:0] la,
  output reg ms_in
);
  initial
  begin
    as_n = 1'b1;
    fc = 4'h0;
    la = 16'h0;
    ms_in = 1'b1;
  end
  task go(input [3:0] f, input [15:0] a, input s);
  begin
    fc = f;
    la = a;
    ms_in = s && (f != 4'h7); // Acknowledge cycles never translated
    as_n = 1'b0;
  end
  endtask
  // Released lines flip so stale values cannot pass
  task stop;
  begin
    as_n = 1'b1;
    la = ~la;
    fc = ~fc;
    ms_in = 1'b1;
  end
  endtask
endmodule

// >>> bench/stm_top_tb_top.sv
`timescale 1ns/1ps
module stm_top_tb_top;
  reg mclk = 1'b0;
  reg rst = 1'b1;
  reg [1:0] mode_pin = 2'h0;
  reg unit_op_done = 1'b0;
  reg load_strobe = 1'b0;
  reg [1:0] load_index = 2'h1;
  reg [3:0] write_protect = 4'h2;
  wire as_n, ms_in, ms, oe, miss, wi;
  wire [3:0] fc;
  wire [15:0] la, pa;
  integer error_cnt = 0;
  integer n_checks = 0;
  integer md, lat, b;
  always #5 mclk = ~mclk;
  stm_cpu stm_cpu_inst (.as_n(as_n), .fc(fc), .la(la), .ms_in(ms_in));
  stm_top stm_top_inst (.mclk(mclk), .rst(rst), .mode_pin(mode_pin),
    .addr_strobe_n(as_n), .function_code_lines(fc),
    .logical_address_lines(la), .mapped_strobe_in(ms_in),
    .unit_op_done(unit_op_done), .load_logical_base(16'h4000),
    .load_logical_mask(16'hc000), .load_physical_base(16'h8000),
    .load_space_number(8'h01), .load_space_mask(8'h7f),
    .load_index(load_index), .load_strobe(load_strobe),
    .write_protect(write_protect), .mapped_strobe(ms),
    .physical_addr_data_lines(pa), .physical_addr_oe(oe),
    .all_miss_out(miss), .write_inhibit(wi));
  task finish_test;
  begin
    if (error_cnt == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  end
  endtask
  task chk(input [18:0] g, input [18:0] e);
  begin
    n_checks = n_checks + 1;
    if (g !== e)
    begin
      error_cnt = error_cnt + 1;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  end
  endtask
  task pulse(input sel);
  begin
    if (sel)
      load_strobe = 1'b1;
    else
      unit_op_done = 1'b1;
    @(negedge mclk);
    load_strobe = 1'b0;
    unit_op_done = 1'b0;
    @(negedge mclk);
  end
  endtask
  task acc(input [3:0] f, input [15:0] a, input [18:0] e);
    integer i;
  begin
    lat = 0;
    stm_cpu_inst.go(f, a, 1'b1);
    for (i = 0; i < 12; i = i + 1)
    begin
      @(negedge mclk);
      if (oe === 1'b1 && ms === 1'b0)
        lat = lat + 1;
    end
    chk({miss, ms, wi, pa}, e);
    chk(ms && !wi, e[17] && !e[16]);
    stm_cpu_inst.stop;
    repeat (5) @(negedge mclk);
  end
  endtask
  initial
  begin
    for (md = 0; md < 3; md = md + 1)
    begin
      rst = 1'b1;
      mode_pin = md;
      repeat (3) @(negedge mclk);
      rst = 1'b0;
      repeat (4) @(negedge mclk);
      b = (md == 1) ? 2 : 1;
      acc(4'h0, 16'h1234, 19'h21234);
      acc(4'h0, 16'h00ff, 19'h200ff);
      chk(lat, b);
      pulse(1'b0);
      acc(4'h0, 16'hff00, 19'h2ff00);
      chk(lat > b && lat <= b + 2, 19'h1);
      acc(4'h1, 16'h1234, 19'h40000);
      pulse(1'b1);
      acc(4'h1, 16'h5678, 19'h39678);
      acc(4'h9, 16'h7f00, 19'h40000);
      acc(4'h1, 16'h8678, 19'h40000);
      acc(4'h7, 16'hffff, 19'h40000);
    end
    finish_test;
  end
  initial
  begin
    #100000;
    error_cnt = error_cnt + 1;
    finish_test;
  end
endmodule
